// >>> shared/aar_pkg.sv
/*
  Shared constants, codes and carrier types of the auto-ack, retry and
  address filter assist. Assumes a 20 MHz core clock.
*/
`default_nettype none
package aar_pkg;
  // Timing, symbol based
  localparam int unsigned AAR_CLK_NS = 50;
  localparam int unsigned AAR_SYMBOL_NS = 16000;
  localparam int unsigned AAR_SYM_CYCLES = AAR_SYMBOL_NS / AAR_CLK_NS;
  localparam int unsigned AAR_TRIG_DELAY_NS = 16000;
  localparam logic [5:0] AAR_TRIG_SYMBOLS = 6'(AAR_TRIG_DELAY_NS / AAR_SYMBOL_NS);
  localparam logic [5:0] AAR_ACK_TURN_SYMBOLS = 6'h0C;
  localparam logic [5:0] AAR_SHORT_ACK_SYMBOLS = 6'h02;
  localparam logic [5:0] AAR_SLOT_SYMBOLS = 6'h06;
  localparam logic [5:0] AAR_ACK_TIMEOUT_SYMBOLS = 6'h36;
  // Transaction result codes
  localparam logic [2:0] AAR_RES_OK = 3'h0;
  localparam logic [2:0] AAR_RES_OK_PEND = 3'h1;
  localparam logic [2:0] AAR_RES_AWAIT_ACK = 3'h2;
  localparam logic [2:0] AAR_RES_BUSY = 3'h3;
  localparam logic [2:0] AAR_RES_NO_ACK = 3'h5;
  localparam logic [2:0] AAR_RES_INVALID = 3'h7;
  localparam logic [2:0] AAR_NO_CSMA = 3'h7;
  localparam int unsigned AAR_ACK_REQ_BIT = 5;
  // Operating modes
  localparam logic [1:0] AAR_MODE_OFF = 2'h0;
  localparam logic [1:0] AAR_MODE_RX = 2'h1;
  localparam logic [1:0] AAR_MODE_TX = 2'h2;
  // Register byte offsets
  localparam logic [5:0] AAR_OFS_RETRY_CTRL = 6'h00;
  localparam logic [5:0] AAR_OFS_ACK_CTRL = 6'h04;
  localparam logic [5:0] AAR_OFS_MODE = 6'h08;
  localparam logic [5:0] AAR_OFS_FILT_CTRL = 6'h0C;
  localparam logic [5:0] AAR_OFS_IRQ_MASK2 = 6'h10;
  localparam logic [5:0] AAR_OFS_BASE_ADDR = 6'h14;
  localparam logic [5:0] AAR_OFS_BASE_CTRL = 6'h18;
  localparam logic [5:0] AAR_OFS_EXT_LO = 6'h1C;
  localparam logic [5:0] AAR_OFS_EXT_HI = 6'h20;
  localparam logic [5:0] AAR_OFS_FILT0 = 6'h24;
  localparam logic [3:0] AAR_FILT_EN_RST = 4'h1;
  localparam logic [15:0] AAR_BROADCAST = 16'hFFFF;

  typedef enum logic [3:0] {
    AAR_ST_IDLE = 4'h0,
    AAR_ST_RX_LISTEN = 4'h1,
    AAR_ST_RX_BUSY = 4'h2,
    AAR_ST_ACK_TURN = 4'h3,
    AAR_ST_ACK_SLOT = 4'h4,
    AAR_ST_ACK_ARMED = 4'h5,
    AAR_ST_ACK_TRIG = 4'h6,
    AAR_ST_ACK_TX = 4'h7,
    AAR_ST_TX_READY = 4'h8,
    AAR_ST_TX_CCA = 4'h9,
    AAR_ST_TX_SEND = 4'hA,
    AAR_ST_TX_ACKWAIT = 4'hB
  } aar_state_type;

  typedef struct packed {
    logic sfd;
    logic frameEnd;
    logic fcsOk;
    logic needsAck;
    logic isAck;
    logic ackPending;
    logic dstNone;
    logic dstIsExt;
    logic [15:0] dstShort;
    logic [15:0] dstPan;
    logic [15:0] srcPan;
    logic [63:0] dstExt;
  } aar_rx_type;

  typedef struct packed {
    logic txDone;
    logic ccaDone;
    logic ccaClear;
    logic [7:0] octet1;
  } aar_tx_type;

  typedef struct packed {
    logic ackTxStart;
    logic ackPendBit;
    logic frameTxStart;
    logic ccaStart;
    logic rxOn;
  } aar_phy_out_type;

  typedef struct packed {
    logic rxEnd;
    logic txEnd;
    logic [3:0] match;
    logic combined;
  } aar_irq_type;
endpackage
`default_nettype wire

// >>> hw/aar_symbol_timer.sv
/*
  Symbol period timer: counts a loaded number of symbol periods and
  pulses on expiry. Assumes the symbol count loaded is nonzero.
*/
`timescale 1ns/1ps
`default_nettype none
module aar_symbol_timer import aar_pkg::*; #(
  parameter int unsigned CYCLES_PER_SYMBOL = AAR_SYM_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [5:0] symbols,
  output logic expired
);
  typedef struct packed {
    logic run;
    logic [15:0] cyc;
    logic [5:0] sym;
    logic expired;
  } aar_tmr_state_type;

  aar_tmr_state_type q, d;

  always_comb begin
    d = q;
    d.expired = 1'b0;
    if (start) begin
      d.run = 1'b1;
      d.cyc = 16'h0000;
      d.sym = symbols;
    end else if (q.run) begin
      if (q.cyc == 16'(CYCLES_PER_SYMBOL - 1)) begin
        d.cyc = 16'h0000;
        if (q.sym == 6'h01) begin
          d.run = 1'b0;
          d.expired = 1'b1;
        end else begin
          d.sym = q.sym - 6'h01;
        end
      end else begin
        d.cyc = q.cyc + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expired = q.expired;
endmodule
`default_nettype wire

// >>> hw/aar_addr_filter.sv
/*
  Parallel destination address filters, one per PAN. Combinational;
  assumes the receive fields are stable at frame end.
*/
`timescale 1ns/1ps
`default_nettype none
module aar_addr_filter import aar_pkg::*; #(
  parameter int unsigned NUM_FILTERS = 4
) (
  input wire logic [NUM_FILTERS-1:0] filtEn,
  input wire logic [NUM_FILTERS-1:0] coord,
  input wire logic [NUM_FILTERS-1:0][15:0] shortAddr,
  input wire logic [NUM_FILTERS-1:0][15:0] panId,
  input wire logic [63:0] extAddr,
  input wire aar_rx_type rx,
  output logic [NUM_FILTERS-1:0] match
);
  logic extHit;
  assign extHit = rx.dstIsExt && (rx.dstExt == extAddr);

  genvar i;
  generate
    for (i = 0; i < NUM_FILTERS; i++) begin : gFilt
      logic panHit;
      logic addrHit;
      logic srcOnlyHit;
      assign panHit = (rx.dstPan == panId[i]) || (rx.dstPan == AAR_BROADCAST);
      assign addrHit = rx.dstIsExt ? extHit :
                       ((rx.dstShort == shortAddr[i]) || (rx.dstShort == AAR_BROADCAST));
      // Source-only frames pass for a coordinator of the same PAN
      assign srcOnlyHit = coord[i] && (rx.srcPan == panId[i]);
      assign match[i] = filtEn[i] && (rx.dstNone ? srcOnlyHit : (panHit && addrHit));
    end
  endgenerate
endmodule
`default_nettype wire

// >>> hw/aar_mac_assist.sv
/*
  Auto-ack receive, multiple address filter and transmit with retry
  assist, with an Avalon-MM register slave.
  Assumes a radio datapath that reports start of frame, frame end, CCA
  and transmit completion as one-cycle pulses on core_clk.
*/
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
// What this block does
// - Slotted ack waits for sleepTrigger input
// - Slotted: await code six symbols after frame
// - Ack starts 16 us after trigger
// - Short turnaround sends ack after two symbols
// - Busy on start delimiter, receive-end on completion
// - Default ack after twelve symbols
// - Four parallel filters, shared extended address
// - Filter zero aliases base address storage
// - Filter zero enabled after reset
// - Per-filter coordinator and pending-data bits
// - Per-filter match interrupt under its mask
// - Combined match interrupt when enabled
// - Retry: CCA, send, transmit-end at finish
// - Channel busy past limit: abort, code 3
// - Ack request read from octet one bit 5
// - Await only ack; result 0 or 1
// - Ack timeout 54 symbols, retry, code 5
// - Entering retry mode sets result 7
// - No ack requested: end at once, 0
// - Channel limit 7: single attempt, no CCA
`timescale 1ns/1ps
`default_nettype none
module aar_mac_assist import aar_pkg::*; #(
  parameter int unsigned SYM_CYCLES = AAR_SYM_CYCLES,
  parameter int unsigned NUM_FILTERS = 4
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic sleepTrigger,
  input wire aar_rx_type rx,
  input wire aar_tx_type tx,
  output aar_phy_out_type phy,
  output aar_irq_type irq
);
  typedef struct packed {
    aar_state_type st;
    logic [2:0] result;
    logic slotted;
    logic [2:0] csmaLimit;
    logic [3:0] frameLimit;
    logic shortAck;
    logic [1:0] mode;
    logic [3:0] filtEn;
    logic [3:0] coord;
    logic [3:0] pend;
    logic [3:0] amiMask;
    logic combEn;
    logic [3:0][15:0] fShort;
    logic [3:0][15:0] fPan;
    logic [63:0] ext;
    logic [2:0] csmaCnt;
    logic [3:0] frameCnt;
    logic waitReq;
    logic [31:0] rdata;
    aar_phy_out_type phy;
    aar_irq_type irq;
  } aar_core_state_type;

  aar_core_state_type q, d;
  logic [3:0] match;
  logic tmrStart;
  logic [5:0] tmrSymbols;
  logic tmrExpired;
  logic wrAcc;
  logic txCmd;
  logic [31:0] rdVal;

  aar_addr_filter #(.NUM_FILTERS(NUM_FILTERS)) uFilter (
    .filtEn(q.filtEn),
    .coord(q.coord),
    .shortAddr(q.fShort),
    .panId(q.fPan),
    .extAddr(q.ext),
    .rx(rx),
    .match(match)
  );

  aar_symbol_timer #(.CYCLES_PER_SYMBOL(SYM_CYCLES)) uTimer (
    .core_clk(core_clk),
    .nrst(nrst),
    .start(tmrStart),
    .symbols(tmrSymbols),
    .expired(tmrExpired)
  );

  // Write takes effect on the edge that the master sees waitrequest low
  assign wrAcc = write && !q.waitReq;
  assign txCmd = wrAcc && (address == AAR_OFS_MODE) && writedata[2] && (q.mode == AAR_MODE_TX);

  // Read mux
  always_comb begin
    rdVal = 32'h0000_0000;
    if (address == AAR_OFS_RETRY_CTRL) begin
      rdVal = {21'h000000, q.frameLimit, q.csmaLimit, q.slotted, q.result};
    end else if (address == AAR_OFS_ACK_CTRL) begin
      rdVal = {31'h0000_0000, q.shortAck};
    end else if (address == AAR_OFS_MODE) begin
      rdVal = {24'h000000, q.st, 2'h0, q.mode};
    end else if (address == AAR_OFS_FILT_CTRL) begin
      rdVal = {20'h00000, q.pend, q.coord, q.filtEn};
    end else if (address == AAR_OFS_IRQ_MASK2) begin
      rdVal = {27'h0000000, q.combEn, q.amiMask};
    end else if (address == AAR_OFS_BASE_ADDR) begin
      rdVal = {q.fPan[0], q.fShort[0]};
    end else if (address == AAR_OFS_BASE_CTRL) begin
      rdVal = {30'h0000_0000, q.pend[0], q.coord[0]};
    end else if (address == AAR_OFS_EXT_LO) begin
      rdVal = q.ext[31:0];
    end else if (address == AAR_OFS_EXT_HI) begin
      rdVal = q.ext[63:32];
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (address == AAR_OFS_FILT0 + 6'(4 * i)) begin
          rdVal = {q.fPan[i], q.fShort[i]};
        end
      end
    end
  end

  always_comb begin
    d = q;
    d.phy.ackTxStart = 1'b0;
    d.phy.frameTxStart = 1'b0;
    d.phy.ccaStart = 1'b0;
    d.irq = '0;
    tmrStart = 1'b0;
    tmrSymbols = AAR_ACK_TURN_SYMBOLS;

    // Avalon slave: one wait cycle, then answer
    if (q.waitReq) begin
      if (read || write) begin
        d.waitReq = 1'b0;
        d.rdata = rdVal;
      end
    end else begin
      d.waitReq = 1'b1;
    end

    case (q.st)
      AAR_ST_IDLE: begin
        d.phy.rxOn = 1'b0;
      end
      AAR_ST_RX_LISTEN: begin
        d.phy.rxOn = 1'b1;
        if (rx.sfd) begin
          d.st = AAR_ST_RX_BUSY;
        end
      end
      AAR_ST_RX_BUSY: begin
        if (rx.frameEnd) begin
          d.st = AAR_ST_RX_LISTEN;
          if (!rx.isAck && (|match)) begin
            d.irq.match = match & q.amiMask;
            d.irq.combined = q.combEn;
          end
          if (rx.fcsOk && !rx.isAck && (|match)) begin
            d.irq.rxEnd = 1'b1;
            if (rx.needsAck) begin
              d.phy.ackPendBit = |(match & q.pend);
              tmrStart = 1'b1;
              if (q.slotted) begin
                tmrSymbols = AAR_SLOT_SYMBOLS;
                d.st = AAR_ST_ACK_SLOT;
              end else begin
                tmrSymbols = q.shortAck ? AAR_SHORT_ACK_SYMBOLS : AAR_ACK_TURN_SYMBOLS;
                d.st = AAR_ST_ACK_TURN;
              end
            end
          end
        end
      end
      AAR_ST_ACK_TURN: begin
        if (tmrExpired) begin
          d.phy.ackTxStart = 1'b1;
          d.st = AAR_ST_ACK_TX;
        end
      end
      AAR_ST_ACK_SLOT: begin
        if (tmrExpired) begin
          d.result = AAR_RES_AWAIT_ACK;
          d.st = AAR_ST_ACK_ARMED;
        end
      end
      AAR_ST_ACK_ARMED: begin
        if (sleepTrigger) begin
          tmrStart = 1'b1;
          tmrSymbols = AAR_TRIG_SYMBOLS;
          d.st = AAR_ST_ACK_TRIG;
        end
      end
      AAR_ST_ACK_TRIG: begin
        if (tmrExpired) begin
          d.phy.ackTxStart = 1'b1;
          d.st = AAR_ST_ACK_TX;
        end
      end
      AAR_ST_ACK_TX: begin
        d.phy.rxOn = 1'b0;
        if (tx.txDone) begin
          d.irq.txEnd = 1'b1;
          d.st = AAR_ST_RX_LISTEN;
        end
      end
      AAR_ST_TX_READY: begin
        d.phy.rxOn = 1'b0;
        if (sleepTrigger || txCmd) begin
          d.csmaCnt = 3'h0;
          d.frameCnt = 4'h0;
          if (q.csmaLimit == AAR_NO_CSMA) begin
            d.phy.frameTxStart = 1'b1;
            d.st = AAR_ST_TX_SEND;
          end else begin
            d.phy.ccaStart = 1'b1;
            d.st = AAR_ST_TX_CCA;
          end
        end
      end
      AAR_ST_TX_CCA: begin
        d.phy.rxOn = 1'b0;
        if (tx.ccaDone) begin
          if (tx.ccaClear) begin
            d.phy.frameTxStart = 1'b1;
            d.st = AAR_ST_TX_SEND;
          end else if (q.csmaCnt == q.csmaLimit) begin
            d.result = AAR_RES_BUSY;
            d.irq.txEnd = 1'b1;
            d.st = AAR_ST_TX_READY;
          end else begin
            d.csmaCnt = q.csmaCnt + 3'h1;
            d.phy.ccaStart = 1'b1;
          end
        end
      end
      AAR_ST_TX_SEND: begin
        if (tx.txDone) begin
          if (tx.octet1[AAR_ACK_REQ_BIT]) begin
            tmrStart = 1'b1;
            tmrSymbols = AAR_ACK_TIMEOUT_SYMBOLS;
            d.phy.rxOn = 1'b1;
            d.st = AAR_ST_TX_ACKWAIT;
          end else begin
            d.result = AAR_RES_OK;
            d.irq.txEnd = 1'b1;
            d.st = AAR_ST_TX_READY;
          end
        end
      end
      AAR_ST_TX_ACKWAIT: begin
        // Other frames are ignored while waiting for the ack
        if (rx.frameEnd && rx.isAck && rx.fcsOk) begin
          d.result = rx.ackPending ? AAR_RES_OK_PEND : AAR_RES_OK;
          d.irq.txEnd = 1'b1;
          d.phy.rxOn = 1'b0;
          d.st = AAR_ST_TX_READY;
        end else if (tmrExpired) begin
          d.phy.rxOn = 1'b0;
          if ((q.csmaLimit == AAR_NO_CSMA) || (q.frameCnt == q.frameLimit)) begin
            d.result = AAR_RES_NO_ACK;
            d.irq.txEnd = 1'b1;
            d.st = AAR_ST_TX_READY;
          end else begin
            d.frameCnt = q.frameCnt + 4'h1;
            d.csmaCnt = 3'h0;
            d.phy.ccaStart = 1'b1;
            d.st = AAR_ST_TX_CCA;
          end
        end
      end
      default: begin
        d.st = AAR_ST_IDLE;
      end
    endcase

    // Register writes; a mode change overrides the sequence above
    if (wrAcc) begin
      if (address == AAR_OFS_RETRY_CTRL) begin
        d.slotted = writedata[3];
        d.csmaLimit = writedata[6:4];
        d.frameLimit = writedata[10:7];
      end else if (address == AAR_OFS_ACK_CTRL) begin
        d.shortAck = writedata[0];
      end else if (address == AAR_OFS_MODE) begin
        if (writedata[1:0] != q.mode) begin
          d.mode = writedata[1:0];
          d.phy.rxOn = 1'b0;
          if (writedata[1:0] == AAR_MODE_TX) begin
            d.result = AAR_RES_INVALID;
            d.st = AAR_ST_TX_READY;
          end else if (writedata[1:0] == AAR_MODE_RX) begin
            d.st = AAR_ST_RX_LISTEN;
          end else begin
            d.st = AAR_ST_IDLE;
          end
        end
      end else if (address == AAR_OFS_FILT_CTRL) begin
        d.filtEn = writedata[3:0];
        d.coord = writedata[7:4];
        d.pend = writedata[11:8];
      end else if (address == AAR_OFS_IRQ_MASK2) begin
        d.amiMask = writedata[3:0];
        d.combEn = writedata[4];
      end else if (address == AAR_OFS_BASE_ADDR) begin
        d.fShort[0] = writedata[15:0];
        d.fPan[0] = writedata[31:16];
      end else if (address == AAR_OFS_BASE_CTRL) begin
        d.coord[0] = writedata[0];
        d.pend[0] = writedata[1];
      end else if (address == AAR_OFS_EXT_LO) begin
        d.ext[31:0] = writedata;
      end else if (address == AAR_OFS_EXT_HI) begin
        d.ext[63:32] = writedata;
      end else begin
        for (int i = 0; i < 4; i++) begin
          if (address == AAR_OFS_FILT0 + 6'(4 * i)) begin
            d.fShort[i] = writedata[15:0];
            d.fPan[i] = writedata[31:16];
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
      q.filtEn <= AAR_FILT_EN_RST;
      q.waitReq <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign readdata = q.rdata;
  assign waitrequest = q.waitReq;
  assign phy = q.phy;
  assign irq = q.irq;
endmodule
`default_nettype wire

// >>> tb/aar_mac_assist_checker.sv
/*
  Port assertions for aar_mac_assist.
  Assumes a bind into every aar_mac_assist instance.
*/
`timescale 1ns/1ps
`default_nettype none
module aar_mac_assist_checker import aar_pkg::*; #(
  parameter int unsigned SYM_CYCLES = AAR_SYM_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic sleepTrigger,
  input wire aar_rx_type rx,
  input wire aar_tx_type tx,
  input wire aar_phy_out_type phy,
  input wire aar_irq_type irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic slotQ, shortQ;
  logic [1:0] modeQ;
  logic [2:0] limQ;
  logic [4:0] maskQ;
  int ackQ, trigQ;
  wire logic acc = write && !waitrequest;
  // Shadow of accepted register writes
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      slotQ <= 1'h0;
      shortQ <= 1'h0;
      modeQ <= 2'h0;
      limQ <= 3'h0;
      maskQ <= 5'h00;
      ackQ <= 0;
      trigQ <= 0;
    end else begin
      if (acc && address == AAR_OFS_RETRY_CTRL) begin
        slotQ <= writedata[3];
        limQ <= writedata[6:4];
      end
      if (acc && address == AAR_OFS_ACK_CTRL) shortQ <= writedata[0];
      if (acc && address == AAR_OFS_MODE) modeQ <= writedata[1:0];
      if (acc && address == AAR_OFS_IRQ_MASK2) maskQ <= writedata[4:0];
      ackQ <= rx.frameEnd ? 1 : ackQ + 1;
      trigQ <= sleepTrigger ? 1 : trigQ + 1;
    end
  end
  property p_bus_answer;
    $rose(read || write) |-> ##1 !waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
  property p_rx_end;
    irq.rxEnd |-> $past(rx.frameEnd) && $past(rx.fcsOk) && !$past(rx.isAck);
  endproperty
  a_rx_end: assert property (p_rx_end) else $error("stray rx end");
  property p_ack_time;
    phy.ackTxStart && !slotQ |-> ackQ == (shortQ ? 2 : 12) * SYM_CYCLES + 2;
  endproperty
  a_ack_time: assert property (p_ack_time) else $error("ack turnaround");
  property p_ack_slot;
    phy.ackTxStart && slotQ |-> trigQ == SYM_CYCLES + 2;
  endproperty
  a_ack_slot: assert property (p_ack_slot) else $error("slotted ack start");
  property p_tx_noack;
    tx.txDone && !tx.octet1[AAR_ACK_REQ_BIT] |=> irq.txEnd;
  endproperty
  a_tx_noack: assert property (p_tx_noack) else $error("tx end missing");
  property p_tx_ackwait;
    tx.txDone && tx.octet1[AAR_ACK_REQ_BIT] && modeQ == AAR_MODE_TX |=> !irq.txEnd && phy.rxOn;
  endproperty
  a_tx_ackwait: assert property (p_tx_ackwait) else $error("ack wait");
  property p_cca_first;
    phy.frameTxStart && limQ != AAR_NO_CSMA |-> $past(tx.ccaDone) && $past(tx.ccaClear);
  endproperty
  a_cca_first: assert property (p_cca_first) else $error("send without clear");
  property p_no_cca;
    phy.ccaStart |-> limQ != AAR_NO_CSMA;
  endproperty
  a_no_cca: assert property (p_no_cca) else $error("cca with limit 7");
  property p_match;
    irq.match != 4'h0 |-> (irq.match & ~maskQ[3:0]) == 4'h0 && $past(rx.frameEnd);
  endproperty
  a_match: assert property (p_match) else $error("match irq");
  property p_comb;
    irq.combined |-> maskQ[4] && $past(rx.frameEnd) && !$past(rx.isAck);
  endproperty
  a_comb: assert property (p_comb) else $error("combined irq");
endmodule
bind aar_mac_assist aar_mac_assist_checker #(.SYM_CYCLES(SYM_CYCLES)) chk_i (
  .core_clk(core_clk), .nrst(nrst), .address(address), .read(read), .write(write),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .sleepTrigger(sleepTrigger), .rx(rx), .tx(tx), .phy(phy), .irq(irq));
`default_nettype wire

// >>> tb/aar_radio_model.sv
/*
  Radio channel partner: answers CCA, sends frames, replies with acks.
  Assumes one-cycle phy pulses from aar_mac_assist.
*/
`timescale 1ns/1ps
`default_nettype none
module aar_radio_model import aar_pkg::*; (
  input wire logic core_clk,
  input wire aar_phy_out_type phy,
  input wire logic frameReq,
  input wire aar_rx_type frameIn,
  input wire logic [3:0] busyIn,
  input wire logic loadBusy,
  input wire logic ackOn,
  input wire logic ackPend,
  input wire logic [7:0] octIn,
  output var aar_rx_type rx,
  output var aar_tx_type tx
);
  aar_rx_type nxt = '0;
  int ccaT = 0, txT = 0, frT = 0;
  logic [3:0] busyQ = 4'h0;
  logic ackDue = 1'h0;
  initial begin
    rx = '0;
    tx = '0;
  end
  always @(posedge core_clk) begin
    tx.ccaDone <= 1'h0;
    tx.txDone <= 1'h0;
    tx.octet1 <= octIn;
    if (loadBusy) busyQ <= busyIn;
    ccaT <= phy.ccaStart ? 4 : (ccaT > 0 ? ccaT - 1 : 0);
    if (ccaT == 1) begin
      tx.ccaDone <= 1'h1;
      tx.ccaClear <= busyQ == 4'h0;
      if (busyQ != 4'h0) busyQ <= busyQ - 4'h1;
    end
    txT <= (phy.frameTxStart || phy.ackTxStart) ? 10 : (txT > 0 ? txT - 1 : 0);
    if (phy.frameTxStart) ackDue <= ackOn && octIn[5];
    if (frameReq) begin
      nxt <= frameIn;
      frT <= 8;
    end else if (txT == 1 && ackDue) begin
      nxt <= '{isAck: 1'h1, fcsOk: 1'h1, ackPending: ackPend, default: '0};
      frT <= 20;
      ackDue <= 1'h0;
    end else if (frT > 0) frT <= frT - 1;
    if (txT == 1) tx.txDone <= 1'h1;
    // Address fields toggle outside frame end
    if (frT == 1) begin
      rx <= nxt;
      rx.frameEnd <= 1'h1;
    end else begin
      rx.frameEnd <= 1'h0;
      rx.dstShort <= ~rx.dstShort;
      rx.dstPan <= ~rx.dstPan;
    end
    rx.sfd <= frT == 5;
  end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
/*
  Self-checking bench for aar_mac_assist with a radio partner.
  Assumes the checker is bound to the design.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top import aar_pkg::*;;
  localparam int unsigned S = 4;
  logic core_clk = 1'h0, nrst = 1'h0, read = 1'h0, write = 1'h0, sleepTrigger = 1'h0;
  logic [5:0] address = 6'h00;
  logic [31:0] writedata = 32'h0, readdata, rd;
  logic waitrequest, frameReq = 1'h0, loadBusy = 1'h0, ackOn = 1'h0, ackPend = 1'h0;
  logic [3:0] busyIn = 4'h0;
  logic [7:0] octIn = 8'h00;
  logic [15:0] sa[4], pa[4];
  logic [23:0] cs;
  aar_rx_type rx, frameIn = '0;
  aar_tx_type tx;
  aar_phy_out_type phy;
  aar_irq_type irq, irqSeen;
  int num_errors = 0, checks_done = 0, ackCnt = 0, ccaCnt = 0, sendCnt = 0;
  int c, cc, sc, cca, sends, res;
  // Fields: limit, busy CCAs, ack request, ack reply, pending, frame retries
  logic [23:0] caseT[6] = '{24'h300000, 24'h150000, 24'h311110, 24'h301100,
    24'h201002, 24'h751002};
  initial forever #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    ackCnt <= ackCnt + phy.ackTxStart;
    ccaCnt <= ccaCnt + phy.ccaStart;
    sendCnt <= sendCnt + phy.frameTxStart;
  end
  aar_mac_assist #(.SYM_CYCLES(S)) aar_mac_assist_i (.core_clk(core_clk), .nrst(nrst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .sleepTrigger(sleepTrigger),
    .rx(rx), .tx(tx), .phy(phy), .irq(irq));
  aar_radio_model aar_radio_model_i (.core_clk(core_clk), .phy(phy), .frameReq(frameReq),
    .frameIn(frameIn), .busyIn(busyIn), .loadBusy(loadBusy), .ackOn(ackOn),
    .ackPend(ackPend), .octIn(octIn), .rx(rx), .tx(tx));
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    read <= !w;
    write <= w;
    do begin
      @(posedge core_clk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'h0;
    write <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic waitp(input logic sel, inout int k);
    do begin
      @(posedge core_clk);
      k++;
    end while ((sel ? irq.txEnd : phy.ackTxStart) !== 1'b1 && k < 9000);
    if (k >= 9000) num_errors++;
  endtask
  task automatic frame(input logic [15:0] s, input logic [15:0] p, input logic na,
      input logic fc);
    int n = 0;
    frameIn <= '{dstShort: s, dstPan: p, needsAck: na, fcsOk: fc, default: '0};
    frameReq <= 1'h1;
    @(posedge core_clk);
    frameReq <= 1'h0;
    do begin
      @(posedge core_clk);
      n++;
    end while (rx.frameEnd !== 1'b1 && n < 50);
    @(posedge core_clk);
    irqSeen = irq;
  endtask
  task automatic trig;
    sleepTrigger <= 1'h1;
    @(posedge core_clk);
    sleepTrigger <= 1'h0;
  endtask
  task test_done;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h1E1B));
    repeat (20) @(posedge core_clk);
    nrst <= 1'h1;
    @(posedge core_clk);
    bus(0, AAR_OFS_FILT_CTRL, 0); check("filt_ctrl", rd, 32'h1);
    bus(0, 6'h3C, 0); check("unmapped", rd, 32'h0);
    // Distinct short per filter via top nibble
    for (int i = 0; i < 4; i++) begin
      sa[i] = 16'(i << 12) | 16'($urandom & 32'hFFF);
      pa[i] = 16'($urandom & 32'h7FFF);
      bus(1, AAR_OFS_FILT0 + 6'(4 * i), {pa[i], sa[i]});
    end
    bus(0, AAR_OFS_BASE_ADDR, 0); check("alias_addr", rd, {pa[0], sa[0]});
    bus(1, AAR_OFS_BASE_CTRL, 1);
    bus(0, AAR_OFS_FILT_CTRL, 0); check("alias_coord", rd, 32'h11);
    bus(1, AAR_OFS_FILT_CTRL, 32'h10F);
    bus(0, AAR_OFS_BASE_CTRL, 0); check("alias_pend", rd, 32'h2);
    bus(1, AAR_OFS_EXT_HI, 32'hC3A5);
    bus(0, AAR_OFS_EXT_HI, 0);
    check("ext_hi", rd, 32'hC3A5);
    bus(1, AAR_OFS_IRQ_MASK2, 32'h15);
    bus(1, AAR_OFS_MODE, AAR_MODE_RX);
    for (int i = 0; i < 4; i++) begin
      frame(sa[i], pa[i], 0, 1);
      check("match", irqSeen.match, 4'((1 << i) & 5));
      check("combined", irqSeen.combined, 1);
      check("rx_end", irqSeen.rxEnd, 1);
    end
    frame(16'h5555, pa[0], 0, 1); check("no_match", irqSeen, 0);
    frame(sa[1], pa[1], 0, 0); check("bad_fcs", irqSeen.rxEnd, 0);
    for (int k = 0; k < 2; k++) begin
      bus(1, AAR_OFS_ACK_CTRL, k);
      frame(sa[0], pa[0], 1, 1);
      c = 1;
      waitp(0, c); check("ack_delay", c, (k ? 2 : 12) * S + 2);
      check("ack_pend", phy.ackPendBit, 1);
      waitp(1, c);
    end
    bus(1, AAR_OFS_ACK_CTRL, 0);
    bus(1, AAR_OFS_RETRY_CTRL, 32'h8);
    frame(sa[2], pa[2], 1, 1);
    c = ackCnt;
    repeat (6 * S + 2) @(posedge core_clk);
    bus(0, AAR_OFS_RETRY_CTRL, 0); check("await_code", rd[2:0], AAR_RES_AWAIT_ACK);
    check("no_auto_ack", ackCnt, c);
    trig;
    c = 0;
    waitp(0, c); check("trig_delay", c, S + 2);
    check("slot_pend", phy.ackPendBit, 0);
    waitp(1, c);
    bus(1, AAR_OFS_RETRY_CTRL, 0);
    bus(1, AAR_OFS_MODE, AAR_MODE_OFF);
    for (int t = 0; t < 6; t++) begin
      cs = caseT[t];
      if (cs[23:20] == 7) begin
        cca = 0;
        sends = 1;
      end else if (cs[19:16] > cs[23:20]) begin
        cca = cs[23:20] + 1;
        sends = 0;
      end else begin
        sends = (cs[15:12] && !cs[11:8]) ? cs[3:0] + 1 : 1;
        cca = cs[19:16] + sends;
      end
      res = sends == 0 ? 3 : !cs[15:12] ? 0 : cs[11:8] ? cs[7:4] : 5;
      bus(1, AAR_OFS_RETRY_CTRL, {cs[3:0], cs[22:20], 4'h0});
      octIn <= {2'h0, cs[12], 5'h01};
      ackOn <= cs[8];
      ackPend <= cs[4];
      busyIn <= cs[19:16];
      loadBusy <= 1'h1;
      bus(1, AAR_OFS_MODE, AAR_MODE_TX);
      loadBusy <= 1'h0;
      bus(0, AAR_OFS_RETRY_CTRL, 0); check("res_invalid", rd[2:0], AAR_RES_INVALID);
      cc = ccaCnt;
      sc = sendCnt;
      if (t == 2) bus(1, AAR_OFS_MODE, 32'h6);
      else trig;
      c = 0;
      waitp(1, c);
      bus(0, AAR_OFS_RETRY_CTRL, 0); check("result", rd[2:0], res);
      check("cca_count", ccaCnt - cc, cca);
      check("send_count", sendCnt - sc, sends);
      bus(1, AAR_OFS_MODE, AAR_MODE_OFF);
    end
    test_done;
  end
  initial begin
    #(50 * 40000);
    num_errors++;
    test_done;
  end
endmodule
`default_nettype wire
